// [hdl/rpc_pkg.sv]
package rpc_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CAUSE_OFS = 8'h04;
    localparam logic [7:0] MODE_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;

    // ---------------------------------------------------------------
    // Control register fields
    // ---------------------------------------------------------------
    localparam int CTRL_BOE_BIT = 0;
    localparam int CTRL_BOIRQ_BIT = 1;
    localparam int CTRL_RPS_BIT = 2;
    localparam int CTRL_SWRST_BIT = 3;
    localparam logic CTRL_BOE_RST = 1'b1;
    localparam logic CTRL_BOIRQ_RST = 1'b0;
    localparam logic CTRL_RPS_RST = 1'b1;

    // Mode request codes written to the mode register
    localparam logic [1:0] MODE_IDLE = 2'h1;
    localparam logic [1:0] MODE_PD = 2'h2;
    localparam logic [1:0] MODE_TPD = 2'h3;

    // Reset stretch after the last cause goes away
    localparam logic [3:0] RST_HOLD_CYC = 4'h8;
    localparam logic [15:0] VEC_NORMAL = 16'h0000;
    localparam logic [7:0] VEC_LOW_BYTE = 8'h00;
    localparam logic [2:0] SYNC_RST = 3'h1;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic brk;
        logic sw;
        logic wdt;
        logic bo;
        logic por;
        logic pin;
    } rpc_cause_t;

    localparam rpc_cause_t CAUSE_POR = 6'h06;

    typedef struct packed {
        logic cpu_halt;
        logic osc_en;
        logic rc_osc_en;
        logic periph_en;
        logic aon_en;
        logic bod_en;
        logic cmp_en;
    } rpc_pwr_t;

    localparam rpc_pwr_t PWR_RST = 7'h3f;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_IDLE = 4'h2,
        ST_PD = 4'h4,
        ST_TPD = 4'h8
    } rpc_state_t;

endpackage

// [hdl/rpc_sync2.sv]
`timescale 1ns/1ps
module rpc_sync2 #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // ---------------------------------------------------------------
    // Two stages; only the second stage is visible outside
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// [hdl/rpc_top.sv]
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
// Function
// - Brownout resets by default; interrupt mode raises a request instead.
// - Software enable bit turns brownout detection fully on or off.
// - Brownout condition follows the below-threshold level while enabled.
// - Power-up sets the power-on flag; it stays until software clears it.
// - Software selects idle, power-down or total power-down.
// - Idle halts the processor; any enabled interrupt or reset ends it.
// - Power-down stops the oscillator; reset or wake interrupt ends it.
// - Brownout, watchdog, comparators and system timer keep running in power-down.
// - RC oscillator off in power-down unless it clocks an enabled system timer.
// - Total power-down also disables brownout detector and comparators.
// - Select bit 1 makes the pin an active-low reset, 0 a plain input.
// - During power-up the pin is always reset; nothing else overrides select.
// - Pin held low during power-on keeps the device in reset.
// - Six reset causes: pin, power-on, brownout, watchdog, software, UART break.
// - Each cause has a readable flag; writing 0 clears; several may be set.
// - Power-on reset sets power-on and brownout flags, clears the others.
// - Other resets set their own flag and keep earlier uncleared flags.
// - Fetch starts at 0000H or at boot vector high byte with 00H low.
// - Boot address after UART break, boot status 1 or forced programming.
module rpc_top (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic RST_PIN_N,
    input wire logic BO_LOW,
    input wire logic POR_DET,
    input wire logic WDT_RST,
    input wire logic UART_BREAK,
    input wire logic IRQ_PEND,
    input wire logic WAKE_IRQ,
    input wire logic BOOT_STATUS,
    input wire logic ISP_FORCE,
    input wire logic [7:0] BOOT_VECTOR,
    input wire logic RC_IS_SYSCLK,
    input wire logic RTC_EN,
    input wire logic CMP_PD,
    output logic SYS_RST_N,
    output logic BO_IRQ,
    output logic PIN_DATA,
    output logic [15:0] RESET_VECTOR,
    output rpc_pkg::rpc_pwr_t PWR
);
    logic [2:0] sync_q;
    logic pin_s, bo_s, por_s, brownout_enable_cfg, bo_irq_mode, rps, sw_req, powering, bo_irq_pend;
    rpc_pkg::rpc_cause_t flags, set_vec;
    rpc_pkg::rpc_state_t state, next_state;
    logic [3:0] rst_cnt;
    logic [7:0] addr_q;
    logic next_rst_n, brk_seen, por_seen, isp_cap, boot_sel, pin_act, det_on, bo_cond;
    logic bo_rst, bo_irq_ev, any_act, acc, wr_q, wr_ctrl, wr_cause, wr_mode;

    // All checks below run on the system clock and sleep while NRST is low
    default clocking cb_sys @(posedge CLK); endclocking
    default disable iff (!NRST);

    // ---------------------------------------------------------------
    // Pin and analog level synchronisers
    // ---------------------------------------------------------------
    rpc_sync2 #(
        .WIDTH(3),
        .RST_VAL(rpc_pkg::SYNC_RST)
    ) u_sync (
        .clk(CLK),
        .nrst(NRST),
        .d({POR_DET, BO_LOW, RST_PIN_N}),
        .q(sync_q)
    );

    assign pin_s = sync_q[0];
    assign bo_s = sync_q[1];
    assign por_s = sync_q[2];

    // Word address decode, shared by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ---------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ---------------------------------------------------------------
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign acc = HSEL && HTRANS[1] && HREADY;
    assign wr_ctrl = wr_q && hit(addr_q, rpc_pkg::CTRL_OFS);
    assign wr_cause = wr_q && hit(addr_q, rpc_pkg::CAUSE_OFS);
    assign wr_mode = wr_q && hit(addr_q, rpc_pkg::MODE_OFS);

    // Address phase capture for the following data phase
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_q <= acc && HWRITE;
            addr_q <= {HADDR[7:2], 2'b00};
        end
    end

    // Read data registered at the address phase; unmapped reads zero
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            HRDATA <= 32'h0000_0000;
        end else if (acc && !HWRITE) begin
            HRDATA <= 32'h0000_0000;
            if (hit({HADDR[7:2], 2'b00}, rpc_pkg::CTRL_OFS)) begin
                HRDATA[2:0] <= {rps, bo_irq_mode, brownout_enable_cfg};
            end else if (hit({HADDR[7:2], 2'b00}, rpc_pkg::CAUSE_OFS)) begin
                HRDATA[5:0] <= flags;
            end else if (hit({HADDR[7:2], 2'b00}, rpc_pkg::MODE_OFS)) begin
                HRDATA[3:0] <= state;
            end else if (hit({HADDR[7:2], 2'b00}, rpc_pkg::STATUS_OFS)) begin
                HRDATA[4:0] <= {boot_sel, powering, pin_s, bo_irq_pend, bo_cond};
            end
        end
    end

    // ---------------------------------------------------------------
    // Control register; software reset is a one-cycle request
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            brownout_enable_cfg <= rpc_pkg::CTRL_BOE_RST;
            bo_irq_mode <= rpc_pkg::CTRL_BOIRQ_RST;
            rps <= rpc_pkg::CTRL_RPS_RST;
            sw_req <= 1'b0;
        end else begin
            sw_req <= wr_ctrl && HWDATA[rpc_pkg::CTRL_SWRST_BIT];
            if (wr_ctrl) begin
                brownout_enable_cfg <= HWDATA[rpc_pkg::CTRL_BOE_BIT];
                bo_irq_mode <= HWDATA[rpc_pkg::CTRL_BOIRQ_BIT];
                rps <= HWDATA[rpc_pkg::CTRL_RPS_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // Reset causes
    // ---------------------------------------------------------------
    // Detector is powered off in total power-down, so it cannot trip
    assign det_on = brownout_enable_cfg && (state != rpc_pkg::ST_TPD);
    assign bo_cond = det_on && bo_s;
    assign bo_rst = bo_cond && !bo_irq_mode;
    assign bo_irq_ev = bo_cond && bo_irq_mode;
    // Power-up forces the reset function whatever the select bit says
    assign pin_act = !pin_s && (powering || rps);
    assign PIN_DATA = pin_s;
    assign any_act = por_s || pin_act || bo_rst || WDT_RST || sw_req
        || UART_BREAK || powering;

    // Power-up phase ends once the detector and the pin both let go
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            powering <= 1'b1;
        end else if (por_s) begin
            powering <= 1'b1;
        end else if (pin_s) begin
            powering <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Internal reset with stretch, released on a clock edge
    // ---------------------------------------------------------------
    assign next_rst_n = !any_act && (rst_cnt == 4'h0);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_cnt <= rpc_pkg::RST_HOLD_CYC;
            SYS_RST_N <= 1'b0;
        end else begin
            if (any_act) begin
                rst_cnt <= rpc_pkg::RST_HOLD_CYC;
            end else if (rst_cnt != 4'h0) begin
                rst_cnt <= rst_cnt - 4'h1;
            end
            SYS_RST_N <= next_rst_n;
        end
    end

    // ---------------------------------------------------------------
    // Sticky cause flags; a set in the clearing cycle wins
    // ---------------------------------------------------------------
    always_comb begin
        set_vec = '0;
        set_vec.pin = pin_act;
        set_vec.bo = bo_rst || bo_irq_ev;
        set_vec.wdt = WDT_RST;
        set_vec.sw = sw_req;
        set_vec.brk = UART_BREAK;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            flags <= rpc_pkg::CAUSE_POR;
        end else if (por_s) begin
            flags <= rpc_pkg::CAUSE_POR;
        end else if (wr_cause) begin
            flags <= (flags & rpc_pkg::rpc_cause_t'(HWDATA[5:0])) | set_vec;
        end else begin
            flags <= flags | set_vec;
        end
    end

    // Brownout request holds until software clears the brownout flag
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            bo_irq_pend <= 1'b0;
        end else if (por_s) begin
            bo_irq_pend <= 1'b0;
        end else if (bo_irq_ev) begin
            bo_irq_pend <= 1'b1;
        end else if (wr_cause && !HWDATA[2]) begin
            bo_irq_pend <= 1'b0;
        end
    end

    assign BO_IRQ = bo_irq_pend;

    // ---------------------------------------------------------------
    // Boot vector choice, latched as the internal reset releases
    // ---------------------------------------------------------------
    assign boot_sel = brk_seen || BOOT_STATUS || (por_seen && isp_cap);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            brk_seen <= 1'b0;
            por_seen <= 1'b1;
            isp_cap <= 1'b0;
            RESET_VECTOR <= rpc_pkg::VEC_NORMAL;
        end else if (next_rst_n && !SYS_RST_N) begin
            brk_seen <= 1'b0;
            por_seen <= 1'b0;
            RESET_VECTOR <= boot_sel ? {BOOT_VECTOR, rpc_pkg::VEC_LOW_BYTE}
                : rpc_pkg::VEC_NORMAL;
        end else begin
            if (UART_BREAK) begin
                brk_seen <= 1'b1;
            end
            if (por_s || powering) begin
                por_seen <= 1'b1;
                isp_cap <= ISP_FORCE; // strap caught while power comes up
            end
        end
    end

    // ---------------------------------------------------------------
    // Power mode state machine
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            rpc_pkg::ST_RUN: begin
                if (wr_mode) begin
                    case (HWDATA[1:0])
                        rpc_pkg::MODE_IDLE: next_state = rpc_pkg::ST_IDLE;
                        rpc_pkg::MODE_PD: next_state = rpc_pkg::ST_PD;
                        rpc_pkg::MODE_TPD: next_state = rpc_pkg::ST_TPD;
                        default: next_state = rpc_pkg::ST_RUN;
                    endcase
                end
            end
            rpc_pkg::ST_IDLE: begin
                if (IRQ_PEND) begin
                    next_state = rpc_pkg::ST_RUN;
                end
            end
            rpc_pkg::ST_PD, rpc_pkg::ST_TPD: begin
                if (WAKE_IRQ) begin
                    next_state = rpc_pkg::ST_RUN;
                end
            end
            default: next_state = rpc_pkg::ST_RUN;
        endcase
        if (any_act || !SYS_RST_N) begin
            next_state = rpc_pkg::ST_RUN;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= rpc_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Gating outputs registered so no decode glitch reaches the clocks
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            PWR <= rpc_pkg::PWR_RST;
        end else begin
            PWR.cpu_halt <= (state != rpc_pkg::ST_RUN);
            PWR.osc_en <= (state == rpc_pkg::ST_RUN) || (state == rpc_pkg::ST_IDLE);
            PWR.periph_en <= (state == rpc_pkg::ST_RUN)
                || (state == rpc_pkg::ST_IDLE);
            PWR.rc_osc_en <= (state == rpc_pkg::ST_RUN) || (state == rpc_pkg::ST_IDLE)
                || (RC_IS_SYSCLK && RTC_EN);
            PWR.aon_en <= 1'b1;
            PWR.bod_en <= det_on;
            PWR.cmp_en <= !CMP_PD && (state != rpc_pkg::ST_TPD);
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_bo_reset;
        (brownout_enable_cfg && !bo_irq_mode && bo_s && state != rpc_pkg::ST_TPD) |=> !SYS_RST_N;
    endproperty
    a_bo_reset: assert property (p_bo_reset) else $error("brownout did not reset");
    property p_bo_off;
        !brownout_enable_cfg |-> !bo_cond && !bo_irq_ev;
    endproperty
    a_bo_off: assert property (p_bo_off) else $error("brownout while disabled");
    property p_bo_irq;
        (bo_irq_ev && !por_s) |=> BO_IRQ && flags.bo && SYS_RST_N == $past(next_rst_n);
    endproperty
    a_bo_irq: assert property (p_bo_irq) else $error("brownout request missing");
    property p_por_flags;
        por_s |=> flags == rpc_pkg::CAUSE_POR;
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");
    property p_keep_flags;
        (!por_s && !wr_cause) |=> ((flags & $past(flags)) == $past(flags));
    endproperty
    a_keep_flags: assert property (p_keep_flags) else $error("flag lost");
    property p_idle_exit;
        (state == rpc_pkg::ST_IDLE && IRQ_PEND) |=> state == rpc_pkg::ST_RUN ##1 !PWR.cpu_halt;
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle not left");
    property p_pd_osc;
        (state == rpc_pkg::ST_PD) ##1 (state == rpc_pkg::ST_PD) |-> !PWR.osc_en && PWR.aon_en;
    endproperty
    a_pd_osc: assert property (p_pd_osc) else $error("oscillator ran in power-down");
    property p_tpd_off;
        (state == rpc_pkg::ST_TPD) |=> !PWR.bod_en && !PWR.cmp_en;
    endproperty
    a_tpd_off: assert property (p_tpd_off) else $error("detectors on in total power-down");
    property p_pwrup_pin;
        (powering && !pin_s) |=> !SYS_RST_N;
    endproperty
    a_pwrup_pin: assert property (p_pwrup_pin) else $error("pin ignored at power-up");
    property p_vector;
        $rose(SYS_RST_N) |-> RESET_VECTOR == ($past(boot_sel)
            ? {$past(BOOT_VECTOR), rpc_pkg::VEC_LOW_BYTE} : rpc_pkg::VEC_NORMAL);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong reset vector");
    property p_hold;
        any_act |=> !SYS_RST_N [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("reset released early");
    c_pd_wake: cover property (state == rpc_pkg::ST_PD ##1 state == rpc_pkg::ST_RUN);
    c_bo_irq: cover property ($rose(BO_IRQ));
    c_boot: cover property ($rose(SYS_RST_N) && RESET_VECTOR != rpc_pkg::VEC_NORMAL);
    c_tpd: cover property (state == rpc_pkg::ST_TPD);
endmodule

// [testbench/rpc_top_tb.sv]
`timescale 1ns/1ps
module rpc_top_tb;
    logic CLK, NRST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic RST_PIN_N, BO_LOW, POR_DET, WDT_RST, UART_BREAK, IRQ_PEND, WAKE_IRQ;
    logic BOOT_STATUS, ISP_FORCE, RC_IS_SYSCLK, RTC_EN, CMP_PD;
    logic SYS_RST_N, BO_IRQ, PIN_DATA;
    logic [7:0] BOOT_VECTOR;
    logic [15:0] RESET_VECTOR;
    rpc_pkg::rpc_pwr_t PWR;
    logic [6:0] pw;
    logic [31:0] seed, rdata, r;
    logic [5:0] flg;
    int n_fail, cmp_count;
    int bitpos [5] = '{3, 5, 0, 2, 4};

    // ---------------------------------------------------------------
    // Clock, design and bus wiring
    // ---------------------------------------------------------------
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    // Single slave, so its ready is the bus ready
    assign HREADY = HREADYOUT;
    assign pw = PWR;
    rpc_top u_rpc_top (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RST_PIN_N(RST_PIN_N), .BO_LOW(BO_LOW),
        .POR_DET(POR_DET), .WDT_RST(WDT_RST), .UART_BREAK(UART_BREAK), .IRQ_PEND(IRQ_PEND),
        .WAKE_IRQ(WAKE_IRQ), .BOOT_STATUS(BOOT_STATUS), .ISP_FORCE(ISP_FORCE),
        .BOOT_VECTOR(BOOT_VECTOR), .RC_IS_SYSCLK(RC_IS_SYSCLK), .RTC_EN(RTC_EN),
        .CMP_PD(CMP_PD), .SYS_RST_N(SYS_RST_N), .BO_IRQ(BO_IRQ), .PIN_DATA(PIN_DATA),
        .RESET_VECTOR(RESET_VECTOR), .PWR(PWR));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected power fields; peripherals in power-down are left unchecked
    function logic [6:0] exp_pwr(input logic [1:0] m, input logic rc, input logic rtc,
                                 input logic cpd);
        logic bod;
        bod = (m == rpc_pkg::MODE_PD);
        // Idle keeps every clock; comparators still obey their own power-down
        if (m == rpc_pkg::MODE_IDLE) return {6'h3f, ~cpd};
        return {1'b1, 1'b0, rc & rtc, 1'b0, 1'b1, bod, bod & ~cpd};
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask
    task stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Sample at the falling edge so registered outputs have settled
    task cyc(input int n);
        repeat (n) @(posedge CLK);
        @(negedge CLK);
    endtask
    task wait_lvl(input logic v, input int n);
        int i;
        i = 0;
        @(negedge CLK);
        while (SYS_RST_N !== v && i < n) begin
            @(negedge CLK);
            i++;
        end
        check(SYS_RST_N, v, "internal reset level");
    endtask
    // Single word transfer; address phase held until ready, then data phase
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h0, a};
        HWRITE <= wr;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HSEL <= 1'b0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rdata = HRDATA;
    endtask
    // Raise one reset cause, drop it, and check flags and fetch address
    task fire(input int k);
        if (k == 4) ahb(1'b1, rpc_pkg::CTRL_OFS, 32'hd);
        @(posedge CLK);
        WDT_RST <= (k == 0);
        UART_BREAK <= (k == 1);
        RST_PIN_N <= (k != 2);
        BO_LOW <= (k == 3);
        wait_lvl(1'b0, 10);
        @(posedge CLK);
        {WDT_RST, UART_BREAK, BO_LOW, RST_PIN_N} <= 4'h1;
        wait_lvl(1'b1, 40);
        flg = flg | (6'h01 << bitpos[k]);
        ahb(1'b0, rpc_pkg::CAUSE_OFS, 32'h0);
        check(rdata, {26'h0, flg}, "cause flags");
        check(RESET_VECTOR, (k == 1 || BOOT_STATUS) ? {BOOT_VECTOR, 8'h00} : 16'h0,
              "fetch address");
    endtask

    // ---------------------------------------------------------------
    // Watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge CLK);
        n_fail++;
        stop_test();
    end
    initial begin
        seed = 32'h0edd;
        {NRST, HSEL, HWRITE, HADDR, HWDATA, HTRANS, HSIZE} = {3'b0, 64'h0, 2'b0, 3'b010};
        {RST_PIN_N, BO_LOW, POR_DET, WDT_RST, UART_BREAK, IRQ_PEND, WAKE_IRQ} = 7'h10;
        {BOOT_STATUS, ISP_FORCE, RC_IS_SYSCLK, RTC_EN, CMP_PD, BOOT_VECTOR} = 13'h0;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        cyc(4);
        @(posedge CLK);
        POR_DET <= 1'b0;
        cyc(20);
        check(SYS_RST_N, 1'b0, "pin low holds reset");
        @(posedge CLK);
        RST_PIN_N <= 1'b1;
        wait_lvl(1'b1, 40);
        ahb(1'b0, rpc_pkg::CAUSE_OFS, 32'h0);
        check(rdata & 32'h3e, 32'h06, "power-up flags");
        check(RESET_VECTOR, 16'h0000, "normal fetch address");
        ahb(1'b0, rpc_pkg::CTRL_OFS, 32'h0);
        check(rdata, 32'h5, "control after reset");
        check({HREADYOUT, HRESP}, 2'b10, "bus ready and okay");
        ahb(1'b1, rpc_pkg::CAUSE_OFS, 32'h0);
        ahb(1'b0, rpc_pkg::CAUSE_OFS, 32'h0);
        flg = 6'h0;
        check(rdata, 32'h0, "flags cleared");
        $display("test power_up done");
        for (int i = 0; i < 6; i++) begin
            r = xs();
            @(posedge CLK);
            BOOT_VECTOR <= r[7:0];
            BOOT_STATUS <= (i == 5);
            fire(i % 5);
        end
        BOOT_STATUS <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            r = xs();
            ahb(1'b1, rpc_pkg::CAUSE_OFS, r);
            flg = flg & r[5:0];
            ahb(1'b0, rpc_pkg::CAUSE_OFS, 32'h0);
            check(rdata, {26'h0, flg}, "masked clear");
        end
        $display("test causes done");
        ahb(1'b1, rpc_pkg::CTRL_OFS, 32'h1);
        RST_PIN_N <= 1'b0;
        cyc(8);
        check({SYS_RST_N, PIN_DATA}, 2'b10, "pin as input low");
        @(posedge CLK);
        RST_PIN_N <= 1'b1;
        cyc(5);
        check(PIN_DATA, 1'b1, "pin as input high");
        ahb(1'b1, rpc_pkg::CTRL_OFS, 32'h7);
        BO_LOW <= 1'b1;
        cyc(8);
        check({SYS_RST_N, BO_IRQ}, 2'b11, "brownout request");
        ahb(1'b0, rpc_pkg::STATUS_OFS, 32'h0);
        check(rdata & 32'h1, 32'h1, "brownout condition");
        flg = flg | 6'h04;
        ahb(1'b0, rpc_pkg::CAUSE_OFS, 32'h0);
        check(rdata, {26'h0, flg}, "brownout flag");
        BO_LOW <= 1'b0;
        cyc(8);
        ahb(1'b0, rpc_pkg::STATUS_OFS, 32'h0);
        check({rdata[0], BO_IRQ}, 2'b01, "condition gone, request held");
        flg = flg & 6'h3b;
        ahb(1'b1, rpc_pkg::CAUSE_OFS, {26'h0, flg});
        cyc(2);
        check(BO_IRQ, 1'b0, "request cleared");
        ahb(1'b1, rpc_pkg::CTRL_OFS, 32'h4);
        BO_LOW <= 1'b1;
        cyc(8);
        ahb(1'b0, rpc_pkg::STATUS_OFS, 32'h0);
        check({SYS_RST_N, BO_IRQ, rdata[0]}, 3'b100, "detection off");
        BO_LOW <= 1'b0;
        ahb(1'b1, rpc_pkg::CTRL_OFS, 32'h5);
        $display("test brownout done");
        for (int i = 0; i < 6; i++) begin
            r = xs();
            @(posedge CLK);
            {CMP_PD, RTC_EN, RC_IS_SYSCLK} <= r[2:0];
            ahb(1'b1, rpc_pkg::MODE_OFS, i % 3 + 1);
            ahb(1'b0, rpc_pkg::MODE_OFS, 32'h0);
            check(rdata, 32'h1 << (i % 3 + 1), "mode entered");
            cyc(1);
            r[6:0] = (i % 3 == 0) ? 7'h7f : 7'h77;
            r[14:8] = exp_pwr(i % 3 + 1, RC_IS_SYSCLK, RTC_EN, CMP_PD) & r[6:0];
            check(pw & r[6:0], r[14:8], "power gating");
            @(posedge CLK);
            if (i % 3 == 0) IRQ_PEND <= 1'b1;
            else WAKE_IRQ <= 1'b1;
            cyc(2);
            @(posedge CLK);
            {IRQ_PEND, WAKE_IRQ} <= 2'b00;
            ahb(1'b0, rpc_pkg::MODE_OFS, 32'h0);
            check(rdata, 32'h1, "woken to run");
        end
        ahb(1'b1, rpc_pkg::MODE_OFS, {30'h0, rpc_pkg::MODE_IDLE});
        fire(0);
        ahb(1'b0, rpc_pkg::MODE_OFS, 32'h0);
        check(rdata, 32'h1, "reset ends idle");
        $display("test modes done");
        ahb(1'b1, rpc_pkg::CTRL_OFS, 32'h1);
        RST_PIN_N <= 1'b0;
        ISP_FORCE <= 1'b1;
        POR_DET <= 1'b1;
        cyc(4);
        @(posedge CLK);
        POR_DET <= 1'b0;
        cyc(20);
        check(SYS_RST_N, 1'b0, "pin is reset in power-up");
        @(posedge CLK);
        RST_PIN_N <= 1'b1;
        wait_lvl(1'b1, 40);
        ahb(1'b0, rpc_pkg::CAUSE_OFS, 32'h0);
        check(rdata & 32'h3e, 32'h06, "power-on flags");
        check(RESET_VECTOR, {BOOT_VECTOR, 8'h00}, "forced boot address");
        $display("test power_on done");
        stop_test();
    end
endmodule
